// *** common/bgfs_map.vh ***
// constants for the bridge gate fault supervisor
`ifndef BGFS_MAP_VH
`define BGFS_MAP_VH

// ******************************************************
// clock and timing
// ******************************************************
`define BGFS_CLK_PERIOD_NS   40
`define BGFS_FIXED_REC_NS    20000
`define BGFS_ADJ_NOM_NS      1000000
`define BGFS_ADJ_MAX_NS      2000000
// least time rounds up, nominal and longest round down
`define BGFS_FIXED_REC_CYC \
   ((`BGFS_FIXED_REC_NS + `BGFS_CLK_PERIOD_NS - 1) / `BGFS_CLK_PERIOD_NS)
`define BGFS_ADJ_NOM_CYC     (`BGFS_ADJ_NOM_NS / `BGFS_CLK_PERIOD_NS)
`define BGFS_ADJ_MAX_CYC     (`BGFS_ADJ_MAX_NS / `BGFS_CLK_PERIOD_NS)

// ******************************************************
// register offsets
// ******************************************************
`define BGFS_OFS_STATUS      4'h0
`define BGFS_OFS_ADJ_DELAY   4'h4
`define BGFS_OFS_FAULT_COUNT 4'h8
`define BGFS_OFS_CAUSE       4'hc

// ******************************************************
// field positions and reset values
// ******************************************************
`define BGFS_BIT_OC          0
`define BGFS_BIT_UV          1
`define BGFS_BIT_OT          2
`define BGFS_BIT_SD          3
`define BGFS_BIT_FLAG_LOW    4
`define BGFS_BIT_PIN_LEVEL   5
`define BGFS_BIT_ADJ_MODE    6
`define BGFS_POS_STATE       8
`define BGFS_RST_ADJ_DELAY   16'h61a8
`define BGFS_RST_COUNT       16'h0000

`endif

// *** hw/bgfs_recovery_timer.v ***
// down counter that times one recovery interval
`timescale 1ns/1ns
`default_nettype none

module bgfs_recovery_timer #(
   parameter W = 16
) (
   input  wire         core_clk_in,
   input  wire         rst_in,
   input  wire         ce_in,
   input  wire         start_in,
   input  wire         abort_in,
   input  wire [W-1:0] load_in,
   output wire         busy_out,
   output wire         done_out
);

   reg [W-1:0] cnt_reg;
   reg [W-1:0] cnt_next;

   // ******************************************************
   // counter
   // ******************************************************
   always @* begin
      cnt_next = cnt_reg;
      if (abort_in) begin
         cnt_next = {W{1'b0}};
      end else if (start_in) begin
         cnt_next = load_in;
      end else if (cnt_reg != {W{1'b0}}) begin
         cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_reg <= {W{1'b0}};
      end else if (ce_in) begin
         cnt_reg <= cnt_next;
      end
   end

   // last cycle of the interval
   assign done_out = (cnt_reg == {{(W-1){1'b0}}, 1'b1}) & ~abort_in;
   assign busy_out = (cnt_reg != {W{1'b0}});

endmodule
`default_nettype wire

// *** hw/bgfs_phase_gate.v ***
// per-phase gate decode with cross-conduction block
`timescale 1ns/1ns
`default_nettype none

module bgfs_phase_gate #(
   parameter N_PHASE = 3
) (
   input  wire               core_clk_in,
   input  wire               rst_in,
   input  wire               ce_in,
   input  wire               off_in,
   input  wire [N_PHASE-1:0] high_in,
   input  wire [N_PHASE-1:0] low_in,
   output wire [N_PHASE-1:0] high_out,
   output wire [N_PHASE-1:0] low_out
);

   reg [N_PHASE-1:0] high_reg;
   reg [N_PHASE-1:0] low_reg;

   genvar g;
   generate
      for (g = 0; g < N_PHASE; g = g + 1) begin : g_phase
         wire both_w;
         assign both_w = high_in[g] & low_in[g];
         always @(posedge core_clk_in) begin
            if (rst_in) begin
               high_reg[g] <= 1'b0;
               low_reg[g]  <= 1'b0;
            end else if (ce_in) begin
               high_reg[g] <= high_in[g] & ~both_w & ~off_in;
               low_reg[g]  <= low_in[g] & ~both_w & ~off_in;
            end
         end
      end
   endgenerate

   assign high_out = high_reg;
   assign low_out  = low_reg;

endmodule
`default_nettype wire

// *** hw/bgfs_supervisor.v ***
// three-phase gate decode and fault supervision with auto recovery
//
// Function
// - input high turns its switch on; both-high blocks phase
// - shunt over-current pulls flag low, switches off
// - after over-current clears, recover after delay
// - supply undervoltage pulls flag low, switches off
// - undervoltage recovers at release, fixed delay always
// - over-temperature pulls flag low, switches off
// - thermal recovery after hysteresis release and delay
// - shutdown input trip pulls flag low, switches off
// - shutdown recovery below release level, then delay
// - recovery_adjustable_in selects adjustable or fixed delay
// - adjustable delay nominal 1.0 ms, max 2.0 ms
// - fixed delay lasts at least 20 us
// - adjust pin held low during over-current, thermal or shutdown fault, not undervoltage
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "bgfs_map.vh"
`timescale 1ns/1ns
`default_nettype none

module bgfs_supervisor #(
   parameter TW          = 16,
   parameter ADJ_NOM_CYC = `BGFS_ADJ_NOM_CYC,
   parameter ADJ_MAX_CYC = `BGFS_ADJ_MAX_CYC
) (
   input  wire        core_clk_in,
   input  wire        rst_in,
   input  wire        ce_in,
   // phase inputs
   input  wire        phase_u_high_in,
   input  wire        phase_v_high_in,
   input  wire        phase_w_high_in,
   input  wire        phase_u_low_in,
   input  wire        phase_v_low_in,
   input  wire        phase_w_low_in,
   // comparator indications
   input  wire        shunt_sense_in,
   input  wire        supply_below_trip_in,
   input  wire        supply_above_release_in,
   input  wire        thermal_trip_in,
   input  wire        thermal_release_in,
   input  wire        shutdown_sense_in,
   input  wire        shutdown_release_in,
   // recovery configuration and adjust pin
   input  wire        recovery_adjustable_in,
   input  wire        recovery_adjust_pin_in,
   output wire        recovery_adjust_pin_out,
   output wire        recovery_adjust_pin_oe_out,
   // fault flag, open drain
   input  wire        fault_flag_in,
   output wire        fault_flag_out,
   output wire        fault_flag_oe_out,
   // switch drives
   output wire        gate_u_high_out,
   output wire        gate_v_high_out,
   output wire        gate_w_high_out,
   output wire        gate_u_low_out,
   output wire        gate_v_low_out,
   output wire        gate_w_low_out,
   // register port
   input  wire [3:0]  reg_addr_in,
   input  wire [31:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output wire [31:0] reg_rdata_out
);

   // ******************************************************
   // states and constants
   // ******************************************************
   localparam [1:0] ST_RUN     = 2'h0;
   localparam [1:0] ST_FAULT   = 2'h1;
   localparam [1:0] ST_RECOVER = 2'h2;

   localparam integer  FIXED_INT = `BGFS_FIXED_REC_CYC;
   localparam integer  MAX_INT   = ADJ_MAX_CYC;
   localparam integer  NOM_INT   = ADJ_NOM_CYC;
   localparam [TW-1:0] FIXED_CYC = FIXED_INT[TW-1:0];
   localparam [TW-1:0] ADJ_MAX   = MAX_INT[TW-1:0];
   localparam [TW-1:0] ADJ_NOM   = NOM_INT[TW-1:0];
   localparam [TW-1:0] ONE       = {{(TW-1){1'b0}}, 1'b1};

   // ******************************************************
   // functions
   // ******************************************************
   // set has priority over clear
   function hold_next;
      input set;
      input clr;
      input cur;
      begin
         hold_next = set | (cur & ~clr);
      end
   endfunction

   // ******************************************************
   // declarations
   // ******************************************************
   reg  [1:0]    state_reg;
   reg  [1:0]    state_next;
   reg           oc_reg;
   reg           uv_reg;
   reg           ot_reg;
   reg           sd_reg;
   reg           uv_seen_reg;
   reg           uv_seen_next;
   reg           flag_oe_reg;
   reg           pin_oe_reg;
   reg  [TW-1:0] adj_delay_reg;
   reg  [15:0]   fault_count_reg;
   reg  [15:0]   fault_count_next;
   reg  [3:0]    cause_reg;
   reg  [3:0]    cause_next;
   reg  [31:0]   rdata_reg;
   reg  [31:0]   rdata_next;
   reg           tmr_start;
   reg           tmr_abort;
   reg  [TW-1:0] tmr_load;
   reg  [TW-1:0] adj_eff;

   wire          oc_nx;
   wire          uv_nx;
   wire          ot_nx;
   wire          sd_nx;
   wire          any_nx;
   wire          tmr_done;
   wire          gates_off;
   wire [3:0]    rise;
   wire [2:0]    high_vec;
   wire [2:0]    low_vec;
   wire [2:0]    high_drv;
   wire [2:0]    low_drv;
   wire [31:0]   status_word;

   // ******************************************************
   // fault condition holding
   // ******************************************************
   // each condition sets on its trip and clears on its release
   assign oc_nx = hold_next(shunt_sense_in, ~shunt_sense_in,
                            oc_reg);
   assign uv_nx = hold_next(supply_below_trip_in,
                            supply_above_release_in,
                            uv_reg);
   assign ot_nx = hold_next(thermal_trip_in, thermal_release_in,
                            ot_reg);
   assign sd_nx = hold_next(shutdown_sense_in, shutdown_release_in,
                            sd_reg);

   assign any_nx = oc_nx | uv_nx | ot_nx | sd_nx;

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         oc_reg <= 1'b0;
         uv_reg <= 1'b0;
         ot_reg <= 1'b0;
         sd_reg <= 1'b0;
      end else if (ce_in) begin
         oc_reg <= oc_nx;
         uv_reg <= uv_nx;
         ot_reg <= ot_nx;
         sd_reg <= sd_nx;
      end
   end

   // ******************************************************
   // recovery delay selection
   // ******************************************************
   always @* begin
      adj_eff = adj_delay_reg;
      if (adj_delay_reg == {TW{1'b0}}) begin
         adj_eff = ONE;
      end else if (adj_delay_reg > ADJ_MAX) begin
         adj_eff = ADJ_MAX;
      end
   end

   always @* begin
      uv_seen_next = uv_seen_reg | uv_nx;
      if (state_next == ST_RUN) begin
         uv_seen_next = 1'b0;
      end
      // undervoltage in the episode forces the fixed interval
      if (uv_seen_next | ~recovery_adjustable_in) begin
         tmr_load = FIXED_CYC;
      end else begin
         tmr_load = adj_eff;
      end
   end

   // ******************************************************
   // supervisor state machine
   // ******************************************************
   always @* begin
      state_next = state_reg;
      tmr_start  = 1'b0;
      tmr_abort  = 1'b0;
      case (state_reg)
         ST_RUN: begin
            if (any_nx) begin
               state_next = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (!any_nx) begin
               state_next = ST_RECOVER;
               tmr_start  = 1'b1;
            end
         end
         ST_RECOVER: begin
            if (any_nx) begin
               state_next = ST_FAULT;
               tmr_abort  = 1'b1;
            end else if (tmr_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_FAULT;
         end
      endcase
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg   <= ST_RUN;
         uv_seen_reg <= 1'b0;
      end else if (ce_in) begin
         state_reg   <= state_next;
         uv_seen_reg <= uv_seen_next;
      end
   end

   bgfs_recovery_timer #(
      .W (TW)
   ) u_timer (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .start_in    (tmr_start),
      .abort_in    (tmr_abort),
      .load_in     (tmr_load),
      .busy_out    (),
      .done_out    (tmr_done)
   );

   // ******************************************************
   // fault flag and adjust pin
   // ******************************************************
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         flag_oe_reg <= 1'b0;
         pin_oe_reg  <= 1'b0;
      end else if (ce_in) begin
         flag_oe_reg <= (state_next != ST_RUN);
         // discharge the timing network while an over-current, thermal or shutdown condition holds
         pin_oe_reg  <= oc_nx | ot_nx | sd_nx;
      end
   end

   assign fault_flag_out             = 1'b0;
   assign fault_flag_oe_out          = flag_oe_reg;
   assign recovery_adjust_pin_out    = 1'b0;
   assign recovery_adjust_pin_oe_out = pin_oe_reg;

   // ******************************************************
   // switch drive
   // ******************************************************
   assign gates_off = (state_next != ST_RUN);
   assign high_vec  = {phase_w_high_in, phase_v_high_in, phase_u_high_in};
   assign low_vec   = {phase_w_low_in, phase_v_low_in, phase_u_low_in};

   bgfs_phase_gate #(
      .N_PHASE (3)
   ) u_gate (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .off_in      (gates_off),
      .high_in     (high_vec),
      .low_in      (low_vec),
      .high_out    (high_drv),
      .low_out     (low_drv)
   );

   assign gate_u_high_out = high_drv[0];
   assign gate_v_high_out = high_drv[1];
   assign gate_w_high_out = high_drv[2];
   assign gate_u_low_out  = low_drv[0];
   assign gate_v_low_out  = low_drv[1];
   assign gate_w_low_out  = low_drv[2];

   // ******************************************************
   // software registers
   // ******************************************************
   assign rise = {sd_nx & ~sd_reg, ot_nx & ~ot_reg,
                  uv_nx & ~uv_reg, oc_nx & ~oc_reg};

   always @* begin
      fault_count_next = fault_count_reg;
      cause_next       = cause_reg;
      if (reg_wr_in && reg_addr_in == `BGFS_OFS_FAULT_COUNT) begin
         fault_count_next = `BGFS_RST_COUNT;
      end
      if (reg_wr_in && reg_addr_in == `BGFS_OFS_CAUSE) begin
         cause_next = cause_reg & ~reg_wdata_in[3:0];
      end
      // new events win over a clear in the same cycle
      if (state_reg == ST_RUN && any_nx) begin
         fault_count_next = fault_count_next + 16'h0001;
      end
      cause_next = cause_next | rise;
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         adj_delay_reg   <= `BGFS_RST_ADJ_DELAY;
         fault_count_reg <= `BGFS_RST_COUNT;
         cause_reg       <= 4'h0;
      end else if (ce_in) begin
         if (reg_wr_in && reg_addr_in == `BGFS_OFS_ADJ_DELAY) begin
            adj_delay_reg <= reg_wdata_in[TW-1:0];
         end
         fault_count_reg <= fault_count_next;
         cause_reg       <= cause_next;
      end
   end

   assign status_word = {22'h000000, state_reg, 1'b0,
                         recovery_adjustable_in,
                         recovery_adjust_pin_in,
                         ~fault_flag_in,
                         sd_reg, ot_reg, uv_reg, oc_reg};

   always @* begin
      rdata_next = 32'h00000000;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `BGFS_OFS_STATUS: begin
               rdata_next = status_word;
            end
            `BGFS_OFS_ADJ_DELAY: begin
               rdata_next[TW-1:0] = adj_delay_reg;
            end
            `BGFS_OFS_FAULT_COUNT: begin
               rdata_next[15:0] = fault_count_reg;
            end
            `BGFS_OFS_CAUSE: begin
               rdata_next[3:0] = cause_reg;
            end
            default: begin
               rdata_next = 32'h00000000;
            end
         endcase
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         rdata_reg <= 32'h00000000;
      end else if (ce_in) begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

endmodule
`default_nettype wire

// *** verification/bgfs_supervisor_sva.sv ***
// assertion checker for the bridge gate fault supervisor
`timescale 1ns/1ns
`default_nettype none

module bgfs_supervisor_sva #(
   parameter ADJ_MAX_CYC = 50000
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic phase_u_high_in,
   input wire logic phase_u_low_in,
   input wire logic shunt_sense_in,
   input wire logic supply_below_trip_in,
   input wire logic supply_above_release_in,
   input wire logic thermal_trip_in,
   input wire logic shutdown_sense_in,
   input wire logic recovery_adjustable_in,
   input wire logic recovery_adjust_pin_oe_out,
   input wire logic fault_flag_oe_out,
   input wire logic gate_u_high_out,
   input wire logic gate_v_high_out,
   input wire logic gate_w_high_out,
   input wire logic gate_u_low_out,
   input wire logic gate_v_low_out,
   input wire logic gate_w_low_out
);
   localparam int FIX = 500;
   localparam int LIM = ((ADJ_MAX_CYC > FIX) ? ADJ_MAX_CYC : FIX) + 4;
   logic [15:0] quiet_cnt;
   logic [15:0] wait_cnt;
   wire         trip_any;
   wire         all_off;
   assign trip_any = shunt_sense_in | supply_below_trip_in
                   | thermal_trip_in | shutdown_sense_in;
   assign all_off = !(gate_u_high_out | gate_v_high_out | gate_w_high_out
                    | gate_u_low_out | gate_v_low_out | gate_w_low_out);

   // cycles since last trip, and cycles spent in recovery
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         quiet_cnt <= 16'h0000;
         wait_cnt  <= 16'h0000;
      end else begin
         quiet_cnt <= trip_any ? 16'h0000 :
                      (&quiet_cnt ? quiet_cnt : quiet_cnt + 16'h0001);
         wait_cnt  <= (fault_flag_oe_out && !recovery_adjust_pin_oe_out &&
                       supply_above_release_in) ?
                      (&wait_cnt ? wait_cnt : wait_cnt + 16'h0001) : 16'h0000;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_oc_gone;
      $fell(shunt_sense_in);
   endsequence
   sequence s_flag_kept;
      fault_flag_oe_out [*8];
   endsequence

   AST_CROSS_BLOCK: assert property (phase_u_high_in && phase_u_low_in
      |=> !gate_u_high_out && !gate_u_low_out)
      else $error("both switches of a phase on together");
   AST_GATE_CAUSE: assert property (gate_u_high_out |->
      $past(phase_u_high_in) && !$past(phase_u_low_in) && !$past(trip_any))
      else $error("top switch on without its cause");
   AST_OC_TRIP: assert property (shunt_sense_in |=> fault_flag_oe_out
      && recovery_adjust_pin_oe_out && all_off)
      else $error("over-current did not stop the bridge");
   AST_UV_TRIP: assert property (supply_below_trip_in
      |=> fault_flag_oe_out && all_off)
      else $error("undervoltage did not stop the bridge");
   AST_OT_TRIP: assert property (thermal_trip_in |=> fault_flag_oe_out
      && recovery_adjust_pin_oe_out && all_off)
      else $error("over-temperature did not stop the bridge");
   AST_SD_TRIP: assert property (shutdown_sense_in |=> fault_flag_oe_out
      && recovery_adjust_pin_oe_out && all_off)
      else $error("shutdown did not stop the bridge");
   AST_PIN_IN_FAULT: assert property (recovery_adjust_pin_oe_out
      |-> fault_flag_oe_out)
      else $error("adjust pin pulled low outside a fault");
   AST_OC_HOLD: assert property (s_oc_gone |-> s_flag_kept)
      else $error("flag released without a recovery delay");
   AST_FIXED_MIN: assert property ($fell(fault_flag_oe_out)
      && !recovery_adjustable_in |-> quiet_cnt >= FIX)
      else $error("fixed recovery shorter than its minimum");
   AST_RECOV_MAX: assert property (wait_cnt <= LIM)
      else $error("recovery lasted too long");
endmodule

bind bgfs_supervisor bgfs_supervisor_sva #(
   .ADJ_MAX_CYC(ADJ_MAX_CYC)
) u_sva (
   .core_clk_in(core_clk_in),
   .rst_in(rst_in),
   .phase_u_high_in(phase_u_high_in),
   .phase_u_low_in(phase_u_low_in),
   .shunt_sense_in(shunt_sense_in),
   .supply_below_trip_in(supply_below_trip_in),
   .supply_above_release_in(supply_above_release_in),
   .thermal_trip_in(thermal_trip_in),
   .shutdown_sense_in(shutdown_sense_in),
   .recovery_adjustable_in(recovery_adjustable_in),
   .recovery_adjust_pin_oe_out(recovery_adjust_pin_oe_out),
   .fault_flag_oe_out(fault_flag_oe_out),
   .gate_u_high_out(gate_u_high_out),
   .gate_v_high_out(gate_v_high_out),
   .gate_w_high_out(gate_w_high_out),
   .gate_u_low_out(gate_u_low_out),
   .gate_v_low_out(gate_v_low_out),
   .gate_w_low_out(gate_w_low_out)
);

`default_nettype wire

// *** verification/bgfs_pwm_src.sv ***
// six-input pwm source standing in for the motor controller
`timescale 1ns/1ns
`default_nettype none

module bgfs_pwm_src (
   input  wire logic       core_clk_in,
   input  wire logic [5:0] pattern_in,
   output var  logic [5:0] phase_out
);
   // order {w,v,u low, w,v,u high}, launched on the clock edge
   always @(posedge core_clk_in) begin
      phase_out <= pattern_in;
   end
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking testbench for the bridge gate fault supervisor
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   logic        core_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [5:0]  pattern = 6'h00;
   logic [5:0]  ph;
   logic        shunt = 1'b0, below = 1'b0, above = 1'b1;
   logic        ttrip = 1'b0, trel = 1'b1, sdsense = 1'b0, sdrel = 1'b1;
   logic        adj = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   wire         pin_oe, flag_oe, pin_lvl, flag_lvl;
   wire  [5:0]  gates;
   int          bad_count = 0, total_checks = 0;

   initial forever #20 core_clk_in = ~core_clk_in;

   bgfs_pwm_src u_src (
      .core_clk_in(core_clk_in), .pattern_in(pattern), .phase_out(ph));

   bgfs_supervisor #(.ADJ_MAX_CYC(100)) dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .phase_u_high_in(ph[0]), .phase_v_high_in(ph[1]),
      .phase_w_high_in(ph[2]), .phase_u_low_in(ph[3]),
      .phase_v_low_in(ph[4]), .phase_w_low_in(ph[5]),
      .shunt_sense_in(shunt), .supply_below_trip_in(below),
      .supply_above_release_in(above), .thermal_trip_in(ttrip),
      .thermal_release_in(trel), .shutdown_sense_in(sdsense),
      .shutdown_release_in(sdrel), .recovery_adjustable_in(adj),
      .recovery_adjust_pin_in(~pin_oe), .recovery_adjust_pin_out(pin_lvl),
      .recovery_adjust_pin_oe_out(pin_oe), .fault_flag_in(~flag_oe),
      .fault_flag_out(flag_lvl), .fault_flag_oe_out(flag_oe),
      .gate_u_high_out(gates[0]), .gate_v_high_out(gates[1]),
      .gate_w_high_out(gates[2]), .gate_u_low_out(gates[3]),
      .gate_v_low_out(gates[4]), .gate_w_low_out(gates[5]),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata));

   // ************************************************
   // helpers
   // ************************************************
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic set_cond(input int k, input logic on);
      @(posedge core_clk_in);
      case (k)
         0: shunt <= on;
         1: begin below <= on; above <= !on; end
         2: begin ttrip <= on; trel <= !on; end
         default: begin sdsense <= on; sdrel <= !on; end
      endcase
   endtask

   // release then time the recovery to flag release
   task automatic release_and_time(input int k, input int len);
      int n;
      set_cond(k, 1'b0);
      for (n = 0; n < 2000 && flag_oe !== 1'b0; n++)
         cyc(1);
      if (n >= 2000) begin
         bad_count++;
         report_and_stop();
      end
      chk(n >= len && n <= len + 2, 1, "recovery length");
      cyc(2);
      chk(gates, 6'h07, "switching resumed");
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_gates;
      logic [5:0] tbl [11] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20,
                               6'h09, 6'h12, 6'h24, 6'h3f, 6'h07};
      foreach (tbl[i]) begin
         pattern <= tbl[i];
         cyc(3);
         chk(gates, {tbl[i][5:3] & ~tbl[i][2:0],
                     tbl[i][2:0] & ~tbl[i][5:3]}, "gate decode");
      end
      $display("test gates done");
   endtask

   task automatic t_fault(input int k, input int len);
      set_cond(k, 1'b1);
      cyc(1);
      chk({flag_oe, pin_oe, gates}, {1'b1, k != 1, 6'h00}, "trip");
      chk({flag_lvl, pin_lvl}, 2'b00, "pins pull low");
      cyc(5);
      release_and_time(k, len);
      $display("test fault %0d adjustable %0b done", k, adj);
   endtask

   task automatic t_retrip;
      set_cond(0, 1'b1);
      cyc(2);
      set_cond(0, 1'b0);
      cyc(20);
      set_cond(0, 1'b1);
      cyc(30);
      chk({flag_oe, gates}, 7'h40, "retrip in recovery");
      release_and_time(0, 40);
      $display("test retrip done");
   endtask

   task automatic t_overlap;
      set_cond(2, 1'b1);
      set_cond(1, 1'b1);
      cyc(3);
      set_cond(2, 1'b0);
      cyc(100);
      chk({flag_oe, pin_oe, gates}, 8'h80, "undervoltage still held");
      release_and_time(1, 500);
      $display("test overlap done");
   endtask

   // trip input gone but release not yet reached: fault must stay
   task automatic t_hyst(input int k);
      set_cond(k, 1'b1);
      @(posedge core_clk_in);
      if (k == 2)
         ttrip <= 1'b0;
      else
         sdsense <= 1'b0;
      cyc(50);
      chk({flag_oe, pin_oe, gates}, 8'hc0, "held above release");
      release_and_time(k, 40);
      $display("test hysteresis %0d done", k);
   endtask

   initial begin
      cyc(8);
      rst_in <= 1'b0;
      cyc(1);
      reg_rd(4'h4, rv);
      chk(rv, 32'h61a8, "delay reset value");
      reg_rd(4'h2, rv);
      chk(rv, 32'h0, "unmapped read");
      t_gates();
      for (int k = 0; k < 4; k++)
         t_fault(k, 500);
      adj <= 1'b1;
      reg_wr(4'h4, 32'd40);
      reg_wr(4'h8, 32'h0);
      reg_wr(4'hc, 32'hf);
      reg_rd(4'h4, rv);
      chk(rv, 32'd40, "delay readback");
      for (int k = 0; k < 4; k++)
         t_fault(k, k == 1 ? 500 : 40);
      reg_rd(4'h8, rv);
      chk(rv, 32'd4, "fault count");
      reg_rd(4'hc, rv);
      chk(rv, 32'hf, "cause bits");
      reg_rd(4'h0, rv);
      chk(rv[6], 1'b1, "mode status");
      t_retrip();
      t_overlap();
      t_hyst(2);
      t_hyst(3);
      reg_wr(4'h4, 32'd200);
      t_fault(0, 100);
      report_and_stop();
   end
endmodule

`default_nettype wire
